// [core/crtram_pkg.sv]
// constants for the crt refresh address mapper
package crtram_pkg;
    // i/o port addresses of the controller index and data ports
    localparam logic [15:0] CRTRAM_IDX_PORT_MONO = 16'h03b4;
    localparam logic [15:0] CRTRAM_DAT_PORT_MONO = 16'h03b5;
    localparam logic [15:0] CRTRAM_IDX_PORT_COLOR = 16'h03d4;
    localparam logic [15:0] CRTRAM_DAT_PORT_COLOR = 16'h03d5;
    // register indices behind the data port
    localparam logic [7:0] CRTRAM_IDX_UNDERLINE = 8'h14;
    localparam logic [7:0] CRTRAM_IDX_MODE_CTRL = 8'h17;
    // reset values
    localparam logic [7:0] CRTRAM_MODE_CTRL_RST = 8'h00;
    localparam logic [7:0] CRTRAM_UNDERLINE_RST = 8'h00;
    localparam logic [7:0] CRTRAM_INDEX_RST = 8'h00;
    // underline location register fields
    localparam int CRTRAM_UL_DWORD_BIT = 6;
    localparam int CRTRAM_UL_QUARTER_BIT = 5;
    // mode control register fields
    localparam int CRTRAM_MC_SYNC_EN_BIT = 7;
    localparam int CRTRAM_MC_WORD_BYTE_BIT = 6;
    localparam int CRTRAM_MC_WRAP_BIT = 5;
    localparam int CRTRAM_MC_HALF_BIT = 3;
    localparam int CRTRAM_MC_RETRACE_SEL_BIT = 2;
    localparam int CRTRAM_MC_ROW_SCAN_SEL_BIT = 1;
    localparam int CRTRAM_MC_COMPAT_BIT = 0;
    // advance intervals in character clocks, minus one, for codes {quarter, half}
    localparam logic [1:0] CRTRAM_DIV_CODE00 = 2'h0;
    localparam logic [1:0] CRTRAM_DIV_CODE01 = 2'h1;
    localparam logic [1:0] CRTRAM_DIV_CODE10 = 2'h3;
    localparam logic [1:0] CRTRAM_DIV_CODE11 = 2'h1;
    // address and counter widths
    localparam int CRTRAM_ADDR_W = 16;
    localparam int CRTRAM_VCOUNT_W = 12;
    // substituted decoder bit positions
    localparam int CRTRAM_SUB_BIT_HI = 14;
    localparam int CRTRAM_SUB_BIT_LO = 13;
    // addressing modes
    typedef enum logic [1:0] {
        CRTRAM_MODE_BYTE,
        CRTRAM_MODE_WORD,
        CRTRAM_MODE_DWORD
    } crtram_mode_e;
endpackage : crtram_pkg

// [core/crtram_shaper.sv]
// combinational address shaping and row scan substitution
`timescale 1ns/1ps
module crtram_shaper (
    input wire logic [15:0] count_in,
    input wire crtram_pkg::crtram_mode_e mode_in,
    input wire logic wrap_in,
    input wire logic row_scan_sel_in,
    input wire logic compat_in,
    input wire logic [1:0] row_scan_bits_in,
    output logic [15:0] decoder_input_bits_out
);
    import crtram_pkg::*;

    logic [15:0] shaped_address_bits; // mode-shaped counter address

    // reorganise counter bits for the addressing mode
    always_comb begin
        case (mode_in)
            CRTRAM_MODE_BYTE: begin
                shaped_address_bits = count_in;
            end
            CRTRAM_MODE_WORD: begin
                // bit 0 wraps at 16kb unless wrap is set
                shaped_address_bits = {count_in[14:0],
                    (wrap_in ? count_in[15] : count_in[13])};
            end
            CRTRAM_MODE_DWORD: begin
                shaped_address_bits = {count_in[13:0], count_in[13], count_in[12]};
            end
            default: begin
                shaped_address_bits = count_in;
            end
        endcase
    end

    // substitution applies after shaping, per bit
    genvar gi;
    generate
        for (gi = 0; gi < CRTRAM_ADDR_W; gi++) begin : g_bit
            if (gi == CRTRAM_SUB_BIT_HI) begin : g_hi
                assign decoder_input_bits_out[gi] = row_scan_sel_in ?
                    shaped_address_bits[gi] : row_scan_bits_in[1];
            end else if (gi == CRTRAM_SUB_BIT_LO) begin : g_lo
                assign decoder_input_bits_out[gi] = compat_in ?
                    shaped_address_bits[gi] : row_scan_bits_in[0];
            end else begin : g_pass
                assign decoder_input_bits_out[gi] = shaped_address_bits[gi];
            end
        end
    endgenerate
endmodule : crtram_shaper

// [core/crtram_top.sv]
// refresh address generation stage of the crt timing unit
`timescale 1ns/1ps
// Operation
// - half clear: advance every 1 or 4 clocks
// - half set: advance every second character clock
// - codes 00,01,10,11 give 1,2,4,2 clocks
// - retrace select halves vertical counter step rate
// - row scan select 0 puts scan bit1 at 14
// - compat bit 0 puts scan bit0 at 13
// - shape first, then substitute before decoder
// - decoder bits 0-12 and 15 never substituted
// - byte mode passes counter bits unchanged
// - word mode shifts one, bit0 from 15/13
// - doubleword shifts two, bits0-1 from 12,13
// - wrap only matters in word mode
module crtram_top (
    input wire logic ref_clk_in, // system clock
    input wire logic reset_in, // synchronous, active high
    input wire logic [15:0] io_addr_in, // i/o port address
    input wire logic io_wr_in, // i/o write strobe
    input wire logic io_rd_in, // i/o read strobe
    input wire logic [7:0] io_wdata_in, // i/o write data
    output logic [7:0] io_rdata_out, // i/o read data
    input wire logic char_clk_en_in, // one-cycle character clock pulse
    input wire logic hretrace_en_in, // one-cycle horizontal retrace clock pulse
    input wire logic frame_start_in, // reload counter at frame start
    input wire logic [15:0] start_addr_in, // start address to reload
    input wire logic vert_restart_in, // clear vertical counter
    input wire logic [1:0] row_scan_bits_in, // current scan line low bits
    output logic [15:0] decoder_input_bits_out, // address to frame buffer decoder
    output logic [15:0] mem_addr_count_out, // refresh memory address counter
    output logic addr_advance_out, // pulse when counter advanced
    output logic [11:0] vert_count_out, // vertical timing counter
    output logic sync_enable_out // sync outputs permitted
);
    import crtram_pkg::*;

    // register file state
    logic [7:0] index_reg; // controller index
    logic [7:0] crt_mode_control; // mode control register
    logic [7:0] underline_location_reg; // underline location register
    logic [7:0] next_index_reg;
    logic [7:0] next_crt_mode_control;
    logic [7:0] next_underline_location_reg;
    logic [7:0] next_io_rdata;
    logic idx_hit; // access to index port
    logic dat_hit; // access to data port

    // decoded controls
    logic quarter_rate_advance;
    logic half_rate_advance;
    crtram_mode_e addr_mode;

    // advance divider and counter state
    logic [1:0] char_div; // character clock divider
    logic [1:0] next_char_div;
    logic [1:0] div_limit; // interval minus one
    logic [15:0] next_count;
    logic next_advance;
    logic [15:0] shaped_addr; // shaper result
    logic [15:0] next_decoder_bits;

    // vertical counter state
    logic retrace_half; // retrace clock divided by two
    logic next_retrace_half;
    logic [11:0] next_vert_count;

    // port decode, both mono and color addresses answer
    always_comb begin
        idx_hit = (io_addr_in == CRTRAM_IDX_PORT_MONO) || (io_addr_in == CRTRAM_IDX_PORT_COLOR);
        dat_hit = (io_addr_in == CRTRAM_DAT_PORT_MONO) || (io_addr_in == CRTRAM_DAT_PORT_COLOR);
    end

    // register writes and read data selection
    always_comb begin
        next_index_reg = index_reg;
        next_crt_mode_control = crt_mode_control;
        next_underline_location_reg = underline_location_reg;
        next_io_rdata = io_rdata_out;
        if (io_wr_in && idx_hit) begin
            next_index_reg = io_wdata_in; // select register
        end
        // data port writes land in the register the index selects
        if (io_wr_in && dat_hit) begin
            if (index_reg == CRTRAM_IDX_MODE_CTRL) begin
                next_crt_mode_control = io_wdata_in;
            end else if (index_reg == CRTRAM_IDX_UNDERLINE) begin
                next_underline_location_reg = io_wdata_in;
            end
        end
        // read data is registered and holds until the next read
        if (io_rd_in) begin
            if (idx_hit) begin
                next_io_rdata = index_reg;
            end else if (dat_hit && index_reg == CRTRAM_IDX_MODE_CTRL) begin
                next_io_rdata = crt_mode_control;
            end else if (dat_hit && index_reg == CRTRAM_IDX_UNDERLINE) begin
                next_io_rdata = underline_location_reg;
            end else begin
                next_io_rdata = 8'h00; // unmapped reads zero
            end
        end
    end

    // register the register file
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            index_reg <= CRTRAM_INDEX_RST;
            crt_mode_control <= CRTRAM_MODE_CTRL_RST;
            underline_location_reg <= CRTRAM_UNDERLINE_RST;
            io_rdata_out <= 8'h00;
        end else begin
            index_reg <= next_index_reg;
            crt_mode_control <= next_crt_mode_control;
            underline_location_reg <= next_underline_location_reg;
            io_rdata_out <= next_io_rdata;
        end
    end

    // control decode
    always_comb begin
        quarter_rate_advance = underline_location_reg[CRTRAM_UL_QUARTER_BIT];
        half_rate_advance = crt_mode_control[CRTRAM_MC_HALF_BIT];
        if (underline_location_reg[CRTRAM_UL_DWORD_BIT]) begin
            addr_mode = CRTRAM_MODE_DWORD;
        end else if (crt_mode_control[CRTRAM_MC_WORD_BYTE_BIT]) begin
            addr_mode = CRTRAM_MODE_BYTE;
        end else begin
            addr_mode = CRTRAM_MODE_WORD;
        end
        case ({quarter_rate_advance, half_rate_advance})
            2'b00: div_limit = CRTRAM_DIV_CODE00;
            2'b01: div_limit = CRTRAM_DIV_CODE01;
            2'b10: div_limit = CRTRAM_DIV_CODE10;
            2'b11: div_limit = CRTRAM_DIV_CODE11;
            default: div_limit = CRTRAM_DIV_CODE00;
        endcase
    end

    // shaping and substitution on the next counter value
    crtram_shaper u_shaper (
        .count_in(next_count),
        .mode_in(addr_mode),
        .wrap_in(crt_mode_control[CRTRAM_MC_WRAP_BIT]),
        .row_scan_sel_in(crt_mode_control[CRTRAM_MC_ROW_SCAN_SEL_BIT]),
        .compat_in(crt_mode_control[CRTRAM_MC_COMPAT_BIT]),
        .row_scan_bits_in(row_scan_bits_in),
        .decoder_input_bits_out(shaped_addr)
    );

    // address counter advance on the divided character clock
    always_comb begin
        next_char_div = char_div;
        next_count = mem_addr_count_out;
        next_advance = 1'b0;
        next_decoder_bits = decoder_input_bits_out;
        // a frame start wins over a coincident character pulse
        if (frame_start_in) begin
            next_count = start_addr_in; // reload restarts the interval
            next_char_div = 2'h0;
        end else if (char_clk_en_in) begin
            if (char_div >= div_limit) begin
                next_char_div = 2'h0;
                next_count = mem_addr_count_out + 16'h0001;
                next_advance = 1'b1;
            end else begin
                next_char_div = char_div + 2'h1;
            end
        end
        // decoder follows every counter load, with this cycle's scan bits
        if (char_clk_en_in || frame_start_in) begin
            next_decoder_bits = shaped_addr;
        end
    end

    // register counter, divider and decoder address
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            char_div <= 2'h0;
            mem_addr_count_out <= 16'h0000;
            addr_advance_out <= 1'b0;
            decoder_input_bits_out <= 16'h0000;
        end else begin
            char_div <= next_char_div;
            mem_addr_count_out <= next_count;
            addr_advance_out <= next_advance;
            decoder_input_bits_out <= next_decoder_bits;
        end
    end

    // vertical counter stepping on retrace clock or half of it
    always_comb begin
        next_retrace_half = retrace_half;
        next_vert_count = vert_count_out;
        // restart wins over a coincident retrace pulse
        if (vert_restart_in) begin
            next_vert_count = 12'h000;
            next_retrace_half = 1'b0;
        end else if (hretrace_en_in) begin
            // half flag toggles on every retrace pulse
            next_retrace_half = ~retrace_half;
            if (!crt_mode_control[CRTRAM_MC_RETRACE_SEL_BIT] || retrace_half) begin
                next_vert_count = vert_count_out + 12'h001;
            end
        end
    end

    // register vertical state and sync enable
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            retrace_half <= 1'b0;
            vert_count_out <= 12'h000;
            sync_enable_out <= 1'b0;
        end else begin
            retrace_half <= next_retrace_half;
            vert_count_out <= next_vert_count;
            sync_enable_out <= crt_mode_control[CRTRAM_MC_SYNC_EN_BIT];
        end
    end
endmodule : crtram_top

// [testbench/crtram_properties.sv]
// assertion checker for the refresh address mapper
`timescale 1ns/1ps
module crtram_properties (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic [15:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    input wire logic [7:0] io_rdata_out,
    input wire logic char_clk_en_in,
    input wire logic hretrace_en_in,
    input wire logic frame_start_in,
    input wire logic vert_restart_in,
    input wire logic [1:0] row_scan_bits_in,
    input wire logic [15:0] decoder_input_bits_out,
    input wire logic [15:0] mem_addr_count_out,
    input wire logic addr_advance_out,
    input wire logic [11:0] vert_count_out
);
    logic [7:0] idx, mc, ul; // shadow index, mode and underline registers
    logic [15:0] shp; // expected mode shaped address
    logic [15:0] c; // counter alias
    wire logic dat = io_addr_in == 16'h03b5 || io_addr_in == 16'h03d5; // data port hit
    assign c = mem_addr_count_out;
    // follow register writes
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            idx <= 8'h00;
            mc <= 8'h00;
            ul <= 8'h00;
        end else if (io_wr_in && (io_addr_in == 16'h03b4 || io_addr_in == 16'h03d4)) begin
            idx <= io_wdata_in;
        end else if (io_wr_in && dat && idx == 8'h17) begin
            mc <= io_wdata_in;
        end else if (io_wr_in && dat && idx == 8'h14) begin
            ul <= io_wdata_in;
        end
    end
    // byte, word or doubleword shaping
    always_comb begin
        if (ul[6]) begin
            shp = {c[13:0], c[13:12]};
        end else if (mc[6]) begin
            shp = c;
        end else begin
            shp = {c[14:0], mc[5] ? c[15] : c[13]};
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    sequence s_load; char_clk_en_in || frame_start_in; endsequence
    sequence s_rd_mode; io_rd_in && dat && idx == 8'h17; endsequence
    sequence s_two_ret;
        (mc[2] && hretrace_en_in && !vert_restart_in) ##1 (hretrace_en_in && !vert_restart_in);
    endsequence
    AST_DEC_KEPT: assert property (s_load |=> decoder_input_bits_out[15] == shp[15] &&
        decoder_input_bits_out[12:0] == shp[12:0]) else $error("kept decoder bits wrong");
    AST_SUB_HI: assert property (s_load |=> decoder_input_bits_out[14] ==
        (mc[1] ? shp[14] : $past(row_scan_bits_in[1]))) else $error("decoder bit 14 wrong");
    AST_SUB_LO: assert property (s_load |=> decoder_input_bits_out[13] ==
        (mc[0] ? shp[13] : $past(row_scan_bits_in[0]))) else $error("decoder bit 13 wrong");
    AST_ADV_STEP: assert property (addr_advance_out |-> $past(char_clk_en_in) &&
        c == $past(c) + 16'h0001) else $error("advance without single step");
    AST_HALF_GAP: assert property (mc[3] && addr_advance_out |=> !addr_advance_out)
        else $error("half rate advanced twice in a row");
    AST_QUARTER_GAP: assert property (ul[5] && !mc[3] && addr_advance_out |=>
        !addr_advance_out [*3]) else $error("quarter rate advanced too soon");
    AST_FULL_RATE: assert property (!ul[5] && !mc[3] && char_clk_en_in && !frame_start_in
        |=> addr_advance_out) else $error("full rate missed an advance");
    AST_VERT_STEP: assert property (!mc[2] && hretrace_en_in && !vert_restart_in |=>
        vert_count_out == $past(vert_count_out) + 12'h001) else $error("vertical step missed");
    AST_VERT_HALF: assert property (s_two_ret |=>
        vert_count_out == $past(vert_count_out, 2) + 12'h001) else $error("halved step wrong");
    AST_VERT_HOLD: assert property (!hretrace_en_in && !vert_restart_in |=>
        $stable(vert_count_out)) else $error("vertical counter moved without retrace");
    AST_READ_MODE: assert property (s_rd_mode |=> io_rdata_out == mc)
        else $error("mode control readback wrong");
endmodule : crtram_properties
bind crtram_top crtram_properties crtram_properties_inst (.ref_clk_in, .reset_in, .io_addr_in,
    .io_wr_in, .io_rd_in, .io_wdata_in, .io_rdata_out, .char_clk_en_in, .hretrace_en_in,
    .frame_start_in, .vert_restart_in, .row_scan_bits_in, .decoder_input_bits_out,
    .mem_addr_count_out, .addr_advance_out, .vert_count_out);

// [testbench/crtram_fb_model.sv]
// frame buffer model answering refresh fetches
`timescale 1ns/1ps
module crtram_fb_model (
    input wire logic ref_clk_in,
    input wire logic [15:0] fetch_addr_in,
    input wire logic fetch_in,
    output logic [7:0] fetch_data_out
);
    // data follows a fetch, otherwise a toggling pattern
    always_ff @(posedge ref_clk_in) begin
        if (fetch_in) begin
            fetch_data_out <= fetch_addr_in[7:0] ^ fetch_addr_in[15:8];
        end else begin
            fetch_data_out <= ~fetch_data_out;
        end
    end
endmodule : crtram_fb_model

// [testbench/crtram_refresh_address_mapper_tb.sv]
// self-checking bench for the refresh address mapper
`timescale 1ns/1ps
module crtram_refresh_address_mapper_tb;
    import crtram_pkg::*;
    logic ref_clk_in = 1'b0, reset_in = 1'b1, io_wr_in = 1'b0, io_rd_in = 1'b0;
    logic char_clk_en_in = 1'b0, hretrace_en_in = 1'b0, frame_start_in = 1'b0;
    logic vert_restart_in = 1'b0, addr_advance_out, sync_enable_out;
    logic [15:0] io_addr_in = 16'h0000, start_addr_in = 16'h0000;
    logic [15:0] decoder_input_bits_out, mem_addr_count_out;
    logic [7:0] io_wdata_in = 8'h00, io_rdata_out, fetch_data, rv;
    logic [1:0] row_scan_bits_in = 2'h0;
    logic [11:0] vert_count_out;
    int fail_count = 0, samples_checked = 0, n;
    int iv [4] = '{1, 2, 4, 2}; // advance interval per rate code
    typedef struct {logic [7:0] ul; logic [7:0] mc; logic [1:0] rs;
        logic [15:0] dec;} crtram_row_s;
    crtram_row_s rows [9] = '{'{8'h00, 8'h43, 2'h3, 16'h95c3}, '{8'h00, 8'h23, 2'h3, 16'h2b87},
        '{8'h00, 8'h03, 2'h3, 16'h2b86}, '{8'h40, 8'h03, 2'h3, 16'h570d},
        '{8'h40, 8'h63, 2'h0, 16'h570d}, '{8'h00, 8'h40, 2'h3, 16'hf5c3},
        '{8'h00, 8'h41, 2'h2, 16'hd5c3}, '{8'h00, 8'h42, 2'h1, 16'hb5c3},
        '{8'h40, 8'h00, 2'h1, 16'h370d}};
    crtram_top crtram_top_inst (.ref_clk_in, .reset_in, .io_addr_in, .io_wr_in, .io_rd_in,
        .io_wdata_in, .io_rdata_out, .char_clk_en_in, .hretrace_en_in, .frame_start_in,
        .start_addr_in, .vert_restart_in, .row_scan_bits_in, .decoder_input_bits_out,
        .mem_addr_count_out, .addr_advance_out, .vert_count_out, .sync_enable_out);
    crtram_fb_model crtram_fb_model_inst (.ref_clk_in, .fetch_addr_in(decoder_input_bits_out),
        .fetch_in(addr_advance_out), .fetch_data_out(fetch_data));
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // one register port write
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk_in);
        io_addr_in = a;
        io_wdata_in = d;
        io_wr_in = 1'b1;
        @(negedge ref_clk_in);
        io_wr_in = 1'b0;
    endtask : wr_reg
    // one register port read
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(negedge ref_clk_in);
        io_addr_in = a;
        io_rd_in = 1'b1;
        @(negedge ref_clk_in);
        io_rd_in = 1'b0;
        @(negedge ref_clk_in);
        d = io_rdata_out;
    endtask : rd_reg
    // underline through colour ports, mode through mono ports
    task automatic set_regs(input logic [7:0] u, input logic [7:0] m);
        wr_reg(16'h03d4, 8'h14);
        wr_reg(16'h03d5, u);
        wr_reg(16'h03b4, 8'h17);
        wr_reg(16'h03b5, m);
    endtask : set_regs
    // frame start reload with a scan line
    task automatic load(input logic [15:0] s, input logic [1:0] r);
        @(negedge ref_clk_in);
        start_addr_in = s;
        row_scan_bits_in = r;
        frame_start_in = 1'b1;
        @(negedge ref_clk_in);
        frame_start_in = 1'b0;
    endtask : load
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(negedge ref_clk_in);
        reset_in = 1'b0;
        foreach (rows[i]) begin
            set_regs(rows[i].ul, rows[i].mc);
            load(16'h95c3, rows[i].rs);
            check(decoder_input_bits_out, rows[i].dec);
            rd_reg(16'h03d5, rv);
            check(rv, rows[i].mc);
            $display("row %0d done", i);
        end
        for (int k = 0; k < 4; k++) begin
            set_regs({2'h0, k[1], 5'h00}, 8'h43 | {4'h0, k[0], 3'h0});
            load(16'h0010, 2'h0);
            n = 0;
            char_clk_en_in = 1'b1;
            repeat (8) begin
                @(negedge ref_clk_in);
                n += addr_advance_out;
            end
            char_clk_en_in = 1'b0;
            check(16'(n), 16'(8 / iv[k]));
            check(mem_addr_count_out, 16'h0010 + 16'(8 / iv[k]));
            // partner answers the last fetch with the address folded to a byte
            @(negedge ref_clk_in);
            check(16'(fetch_data), 16'h0010 + 16'(8 / iv[k]));
        end
        $display("advance rates done");
        for (int k = 0; k < 2; k++) begin
            set_regs(8'h00, 8'h43 | {5'h00, k[0], 2'h0});
            @(negedge ref_clk_in);
            vert_restart_in = 1'b1;
            @(negedge ref_clk_in);
            vert_restart_in = 1'b0;
            hretrace_en_in = 1'b1;
            repeat (4) @(negedge ref_clk_in);
            hretrace_en_in = 1'b0;
            check(16'(vert_count_out), 16'(4 >> k));
        end
        $display("vertical done");
        // sync permit bit, underline readback and index readback
        set_regs(8'h60, 8'hc3);
        @(negedge ref_clk_in);
        check(16'(sync_enable_out), 16'h0001);
        wr_reg(16'h03d4, 8'h14);
        rd_reg(16'h03d5, rv);
        check(rv, 8'h60);
        wr_reg(16'h03d4, 8'h22);
        wr_reg(16'h03d5, 8'h5a);
        rd_reg(16'h03d4, rv);
        check(rv, 8'h22);
        rd_reg(16'h03d5, rv);
        check(rv, 8'h00);
        // refused write left mode alone, then an unmapped address
        wr_reg(16'h03d4, 8'h17);
        rd_reg(16'h03d5, rv);
        check(rv, 8'hc3);
        rd_reg(16'h0123, rv);
        check(rv, 8'h00);
        $display("refused access done");
        @(negedge ref_clk_in);
        reset_in = 1'b1;
        @(negedge ref_clk_in);
        reset_in = 1'b0;
        check(decoder_input_bits_out, 16'h0000);
        check(mem_addr_count_out, 16'h0000);
        check(16'(vert_count_out), 16'h0000);
        check(16'(sync_enable_out), 16'h0000);
        wr_reg(16'h03d4, 8'h17);
        rd_reg(16'h03d5, rv);
        check(rv, 8'h00);
        $display("second reset done");
        report_and_stop();
    end
endmodule : crtram_refresh_address_mapper_tb
